/* bls_framer.sv */
// reply frame builder and receive classifier for basic and extended link services
`include "bls_params.svh"
module bls_framer
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire bls_pkg::op_t cmd_op,
   input wire logic [23:0] cmd_d_id,
   input wire logic [23:0] cmd_s_id,
   input wire logic [15:0] cmd_ox_id,
   input wire logic [15:0] cmd_rx_id,
   input wire logic [15:0] cmd_seq_cnt,
   input wire logic [7:0] cmd_code,
   input wire logic cmd_ec,
   input wire logic cmd_sofc1,
   input wire logic rej_valid,
   input wire logic [7:0] rej_code,
   input wire logic [7:0] rej_expl,
   input wire logic [7:0] rej_vendor,
   input wire logic rx_valid,
   input wire logic [7:0] rx_r_ctl,
   input wire logic [7:0] rx_type,
   input wire logic [23:0] rx_f_ctl,
   input wire logic rx_sofc1,
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [31:0] tx_data,
   output logic tx_last,
   output logic tx_sofc1,
   output logic conn_remove,
   output logic ack_dt_req,
   output logic seq_abort,
   output logic conn_end_seen,
   output logic conn_open_seen,
   output logic els_req_seen,
   output logic els_rep_seen
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   bls_pkg::state_t state; // frame sequencer
   bls_pkg::op_t cur_op; // frame being sent
   logic [31:0] frame [0:8]; // header and payload words
   logic [3:0] idx; // word being offered
   logic [3:0] last_idx; // index of final word
   logic cur_rjt; // current abort reply is a reject
   logic [7:0] seq_id; // next sequence id
   logic [4:0] ctrl; // software control bits
   logic [8:0] last_seq; // valid flag and last deliverable id
   logic rej_held; // a reject condition is latched
   logic [31:0] rej_word; // latched reason word
   logic [31:0] frames_sent; // completed frames
   logic take; // command accepted
   logic done; // final word taken

   // picks whether an accepted els command closes its exchange
   function automatic logic els_closes(input logic [7:0] code);
      els_closes = !(code == `ELS_ESTS || code == `ELS_ESTC || code == `ELS_ADVC);
   endfunction : els_closes

   // ----------------------------------------------------------------
   // command intake
   // ----------------------------------------------------------------
   // rmc is only offered when software explicitly allows it
   assign cmd_ready = ce && state == bls_pkg::st_idle
      && (cmd_op != bls_pkg::op_rmc || ctrl[3]);
   assign take = cmd_valid && cmd_ready;
   assign done = ce && state == bls_pkg::st_send && tx_ready && idx == last_idx;
   assign tx_valid = state == bls_pkg::st_send;
   assign tx_last = tx_valid && idx == last_idx;

   // ----------------------------------------------------------------
   // first reject condition latch
   // ----------------------------------------------------------------
   // holds the first condition until the abort reply command is taken; a new one
   // arriving with the clear is kept for the next request
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rej_held <= 1'b0;
         rej_word <= 32'h00000000;
      end
      else if (ce)
      begin
         if (rej_valid && (!rej_held || (take && cmd_op == bls_pkg::op_abts_reply)))
         begin
            rej_held <= 1'b1;
            // top byte zero, vendor byte only with vendor code
            rej_word <= {8'h00, rej_code, rej_expl,
               (rej_code == `RSN_VENDOR) ? rej_vendor : 8'h00};
         end
         else if (take && cmd_op == bls_pkg::op_abts_reply)
            rej_held <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // frame assembly
   // ----------------------------------------------------------------
   // builds every word of the frame at the moment the command is taken
   always_ff @(posedge core_clk)
   begin
      if (ce && take)
      begin
         frame[3] <= {seq_id, 8'h00, 16'h0000};
         frame[4] <= {cmd_ox_id, cmd_rx_id};
         frame[5] <= 32'h00000000;
         frame[6] <= 32'h00000000;
         frame[7] <= 32'h00000000;
         frame[8] <= 32'h00000000;
         case (cmd_op)
            bls_pkg::op_abts_reply:
            begin
               // reply goes back to the requester
               frame[1] <= {8'h00, cmd_d_id};
               if (rej_held)
               begin
                  frame[0] <= {`RCTL_BA_RJT, cmd_s_id};
                  frame[2] <= {`TYPE_BLS, 24'h0} | (24'h1 << `FC_ES)
                     | (24'(ctrl[1]) << `FC_SI);
                  frame[6] <= rej_word;
               end
               else
               begin
                  frame[0] <= {`RCTL_BA_ACC, cmd_s_id};
                  frame[2] <= {`TYPE_BLS, 24'h0} | (24'h1 << `FC_ES)
                     | (24'(ctrl[1]) << `FC_SI)
                     | (24'(ctrl[2]) << `FC_LS);
                  frame[6] <= {last_seq[8] ? `SEQ_VALID : `SEQ_INVALID,
                     last_seq[7:0], 16'h0000};
                  frame[7] <= {cmd_ox_id, cmd_rx_id};
                  // aborting the exchange spans the whole count range
                  frame[8] <= ctrl[2] ? {`CNT_ABORT_LO, `CNT_ABORT_HI}
                     : {cmd_seq_cnt, cmd_seq_cnt};
               end
            end
            bls_pkg::op_nop:
            begin
               frame[0] <= {`RCTL_NOP, cmd_d_id};
               frame[1] <= {8'h00, cmd_s_id};
               // teardown is signalled only by the end connection bit
               frame[2] <= {`TYPE_BLS, 24'h0} | (24'(cmd_ec) << `FC_EC)
                  | (24'h1 << `FC_ES);
            end
            bls_pkg::op_rmc:
            begin
               frame[0] <= {`RCTL_RMC, cmd_d_id};
               frame[1] <= {8'h00, cmd_s_id};
               frame[2] <= {`TYPE_BLS, 24'h0} | (24'h1 << `FC_ES);
            end
            default:
            begin
               // extended accept: solicited control, fixed type
               frame[0] <= {`RCTL_ELS, `INFO_SOL, cmd_s_id};
               frame[1] <= {8'h00, cmd_d_id};
               frame[2] <= {`TYPE_ELS, 24'h0} | (24'h1 << `FC_ES)
                  | (24'(els_closes(cmd_code)) << `FC_LS);
               frame[6] <= {`ELS_ACC, 24'h000000};
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // frame sequencer
   // ----------------------------------------------------------------
   // load one cycle, then offer words until the last is taken
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= bls_pkg::st_idle;
         cur_op <= bls_pkg::op_nop;
         cur_rjt <= 1'b0;
         idx <= 4'h0;
         last_idx <= 4'h0;
         tx_data <= 32'h00000000;
         tx_sofc1 <= 1'b0;
      end
      else if (ce)
      begin
         case (state)
            bls_pkg::st_idle:
            begin
               if (take)
               begin
                  state <= bls_pkg::st_load;
                  cur_op <= cmd_op;
                  cur_rjt <= rej_held;
                  idx <= 4'h0;
                  tx_sofc1 <= cmd_op == bls_pkg::op_nop && cmd_sofc1;
                  // nop and rmc have no payload
                  case (cmd_op)
                     bls_pkg::op_abts_reply: last_idx <= rej_held ? `LAST_RJT : `LAST_ACC;
                     bls_pkg::op_els_acc: last_idx <= `LAST_ELS;
                     default: last_idx <= `LAST_HDR;
                  endcase
               end
            end
            bls_pkg::st_load:
            begin
               tx_data <= frame[0];
               state <= bls_pkg::st_send;
            end
            bls_pkg::st_send:
            begin
               if (tx_ready)
               begin
                  if (idx == last_idx)
                  begin
                     state <= bls_pkg::st_idle;
                     tx_sofc1 <= 1'b0;
                  end
                  else
                  begin
                     idx <= idx + 4'h1;
                     tx_data <= frame[idx + 4'h1];
                  end
               end
            end
            default: state <= bls_pkg::st_idle;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // sequence id and frame count
   // ----------------------------------------------------------------
   // each sent frame opens a new sequence with a fresh id
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         seq_id <= 8'h00;
         frames_sent <= 32'h00000000;
      end
      else if (ce && done)
      begin
         seq_id <= seq_id + 8'h01;
         frames_sent <= frames_sent + 32'h1;
      end
   end

   // ----------------------------------------------------------------
   // receive classifier
   // ----------------------------------------------------------------
   // only raises events; no received frame here ever starts a reply
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         conn_remove <= 1'b0;
         ack_dt_req <= 1'b0;
         seq_abort <= 1'b0;
         conn_end_seen <= 1'b0;
         conn_open_seen <= 1'b0;
         els_req_seen <= 1'b0;
         els_rep_seen <= 1'b0;
      end
      else if (ce)
      begin
         // remove connection at once and abort open sequences
         conn_remove <= rx_valid && rx_r_ctl == `RCTL_RMC && rx_type == `TYPE_BLS;
         ack_dt_req <= rx_valid && rx_r_ctl == `RCTL_RMC && rx_type == `TYPE_BLS;
         seq_abort <= rx_valid && rx_r_ctl == `RCTL_RMC && rx_type == `TYPE_BLS;
         // nop frame control and delimiters still acted on
         conn_end_seen <= rx_valid && rx_r_ctl == `RCTL_NOP && rx_f_ctl[`FC_EC];
         conn_open_seen <= rx_valid && rx_r_ctl == `RCTL_NOP && rx_sofc1;
         els_req_seen <= rx_valid && rx_r_ctl == {`RCTL_ELS, `INFO_UNSOL}
            && rx_type == `TYPE_ELS;
         els_rep_seen <= rx_valid && rx_r_ctl == {`RCTL_ELS, `INFO_SOL}
            && rx_type == `TYPE_ELS;
      end
   end

   // ----------------------------------------------------------------
   // register slave
   // ----------------------------------------------------------------
   assign s_axi_awready = ce && !s_axi_bvalid && s_axi_awvalid && s_axi_wvalid;
   assign s_axi_wready = s_axi_awready;
   assign s_axi_arready = ce && !s_axi_rvalid;

   // write path: address and data taken together, answer next cycle
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl <= 5'h00;
         last_seq <= 9'h000;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end
      else if (ce)
      begin
         if (s_axi_awready)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `RESP_OKAY;
            if (s_axi_awaddr == `REG_CTRL && s_axi_wstrb[0])
               ctrl <= s_axi_wdata[4:0];
            else if (s_axi_awaddr == `REG_LASTSEQ)
            begin
               if (s_axi_wstrb[0])
                  last_seq[7:0] <= s_axi_wdata[7:0];
               if (s_axi_wstrb[1])
                  last_seq[8] <= s_axi_wdata[8];
            end
            else if (s_axi_awaddr != `REG_STATUS && s_axi_awaddr != `REG_REJWORD
               && s_axi_awaddr != `REG_FRAMES)
               s_axi_bresp <= `RESP_DECERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // read path: one cycle to data
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end
      else if (ce)
      begin
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            case (s_axi_araddr)
               `REG_CTRL: s_axi_rdata <= {27'h0, ctrl};
               `REG_LASTSEQ: s_axi_rdata <= {23'h0, last_seq};
               `REG_STATUS: s_axi_rdata <= {16'h0, seq_id, 6'h0, rej_held,
                  state != bls_pkg::st_idle};
               `REG_REJWORD: s_axi_rdata <= rej_word;
               `REG_FRAMES: s_axi_rdata <= frames_sent;
               default:
               begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= `RESP_DECERR;
               end
            endcase
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking chk_clk @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence rmc_in;
      ce && rx_valid && rx_r_ctl == `RCTL_RMC && rx_type == `TYPE_BLS;
   endsequence
   sequence abts_take;
      take && cmd_op == bls_pkg::op_abts_reply;
   endsequence

   // unstalled reply: the control word is on the bus four cycles after the take
   a_si_on_reply: assert property (abts_take ##1 ce ##1 (ce && tx_ready)
      ##1 (ce && tx_ready) |=> tx_data[`FC_SI] == $past(ctrl[1], 4))
      else $error("sequence initiative bit wrong");
   a_si_kept: assert property ((abts_take and !ctrl[1]) |=> !frame[2][`FC_SI])
      else $error("initiative bit set while kept");
   a_acc_ids: assert property (abts_take |=> frame[4][31:16] == $past(cmd_ox_id)
      && frame[4][15:0] == $past(cmd_rx_id))
      else $error("exchange ids not echoed");
   a_addr_swap: assert property (abts_take |=> frame[0][23:0] == $past(cmd_s_id)
      && frame[1][23:0] == $past(cmd_d_id))
      else $error("reply addresses not swapped");
   a_rjt_length: assert property ((abts_take and rej_held) |=> last_idx == `LAST_RJT
      && frame[0][31:24] == `RCTL_BA_RJT)
      else $error("reject frame wrong length");
   a_rej_top_zero: assert property (rej_held |-> rej_word[31:24] == 8'h00)
      else $error("reserved reason byte not zero");
   a_first_reject: assert property (rej_held && ce && rej_valid && !take |=> $stable(rej_word))
      else $error("later reject overwrote first");
   a_rmc_ack: assert property (rmc_in |=> conn_remove && ack_dt_req && seq_abort)
      else $error("rmc not acted on");
   a_no_reply: assert property (state == bls_pkg::st_idle && !take |=> state == bls_pkg::st_idle)
      else $error("frame sent without command");
   a_rmc_gated: assert property (cmd_op == bls_pkg::op_rmc && !ctrl[3] |-> !cmd_ready)
      else $error("rmc sent without permission");
endmodule : bls_framer

/* bls_params.svh */
// constants of the basic and extended link service reply framer
`ifndef BLS_PARAMS_SVH
`define BLS_PARAMS_SVH
// ----------------------------------------------------------------
// routing and type
// ----------------------------------------------------------------
`define RCTL_BA_ACC 8'h84
`define RCTL_BA_RJT 8'h85
`define RCTL_NOP 8'h80
`define RCTL_RMC 8'h82
`define RCTL_BLS 4'h8
`define RCTL_ELS 4'h2
`define INFO_UNSOL 4'h2
`define INFO_SOL 4'h3
`define TYPE_BLS 8'h00
`define TYPE_ELS 8'h01
// ----------------------------------------------------------------
// frame control bit positions
// ----------------------------------------------------------------
`define FC_SI 16
`define FC_EC 18
`define FC_ES 19
`define FC_LS 20
// ----------------------------------------------------------------
// payload values
// ----------------------------------------------------------------
`define SEQ_VALID 8'h80
`define SEQ_INVALID 8'h00
`define CNT_ABORT_LO 16'h0000
`define CNT_ABORT_HI 16'hffff
`define RSN_INV_CMD 8'h01
`define RSN_LOGIC 8'h03
`define RSN_BUSY 8'h05
`define RSN_PROTO 8'h07
`define RSN_UNABLE 8'h09
`define RSN_VENDOR 8'hff
`define EXPL_NONE 8'h00
`define EXPL_BAD_XID 8'h03
`define EXPL_NO_SEQ 8'h05
`define ELS_ACC 8'h02
`define ELS_ESTS 8'h0b
`define ELS_ESTC 8'h0c
`define ELS_ADVC 8'h0d
// ----------------------------------------------------------------
// frame lengths (index of the last word) and register map
// ----------------------------------------------------------------
`define LAST_HDR 4'h5
`define LAST_ACC 4'h8
`define LAST_RJT 4'h6
`define LAST_ELS 4'h6
`define REG_CTRL 8'h00
`define REG_LASTSEQ 8'h04
`define REG_STATUS 8'h08
`define REG_REJWORD 8'h0c
`define REG_FRAMES 8'h10
`define RESP_OKAY 2'b00
`define RESP_DECERR 2'b11
`endif

/* bls_pkg.sv */
// types shared by the link service reply framer
package bls_pkg;
   typedef enum logic [1:0] {op_abts_reply, op_nop, op_rmc, op_els_acc} op_t;
   typedef enum logic [1:0] {st_idle, st_load, st_send} state_t;
endpackage : bls_pkg

/* peer_port.sv */
// far-side port model: takes reply frames, stalls on request, never replies
module peer_port
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic slow,
   input wire logic tx_valid,
   input wire logic [31:0] tx_data,
   input wire logic tx_last,
   input wire logic tx_sofc1,
   output logic tx_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] w [0:15]; // words of the latest frame
   logic [3:0] nw; // words in the latest frame
   logic done; // latest frame complete
   logic c1; // class 1 open delimiter flagged with the frame
   logic ph; // stall phase
   // ready every cycle, or every other one when stalling; no reply frame is sent
   assign tx_ready = !slow || ph;
   // -------------------------------------------------------
   // frame capture
   // -------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ph <= 1'b0;
         nw <= 4'h0;
         done <= 1'b1;
         c1 <= 1'b0;
      end
      else
      begin
         ph <= !ph;
         // a word after a finished frame starts a new one
         if (tx_valid && tx_ready)
         begin
            w[done ? 4'h0 : nw] <= tx_data;
            nw <= done ? 4'h1 : nw + 4'h1;
            done <= tx_last;
            c1 <= tx_sofc1;
         end
      end
   end
endmodule : peer_port

/* testbench.sv */
// self-checking bench of the link service reply framer
`include "bls_params.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, slow = 1'b0;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, cmd_code = '0, rx_r_ctl = '0, rx_type = '0;
   logic [7:0] rej_code = '0, rej_expl = '0, rej_vendor = '0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cmd_valid = 1'b0, cmd_ec = 1'b0;
   logic cmd_sofc1 = 1'b0, rej_valid = 1'b0, rx_valid = 1'b0, rx_sofc1 = 1'b0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, tx_data;
   logic [3:0] s_axi_wstrb = 4'hf;
   bls_pkg::op_t cmd_op = bls_pkg::op_nop;
   logic [23:0] cmd_d_id = '0, cmd_s_id = '0, rx_f_ctl = '0;
   logic [15:0] cmd_ox_id = '0, cmd_rx_id = '0, cmd_seq_cnt = '0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cmd_ready;
   logic tx_valid, tx_ready, tx_last, tx_sofc1, conn_remove, ack_dt_req, seq_abort;
   logic conn_end_seen, conn_open_seen, els_req_seen, els_rep_seen;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int miscompares = 0, n_checks = 0;
   wire logic [6:0] ev = {conn_remove, ack_dt_req, seq_abort, conn_end_seen, conn_open_seen,
      els_req_seen, els_rep_seen}; // receive event pulses
   always #4 core_clk = ~core_clk;
   bls_framer u_dut (.core_clk, .rst_n, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .cmd_valid, .cmd_ready, .cmd_op, .cmd_d_id, .cmd_s_id,
      .cmd_ox_id, .cmd_rx_id, .cmd_seq_cnt, .cmd_code, .cmd_ec, .cmd_sofc1, .rej_valid,
      .rej_code, .rej_expl, .rej_vendor, .rx_valid, .rx_r_ctl, .rx_type, .rx_f_ctl, .rx_sofc1,
      .tx_valid, .tx_ready, .tx_data, .tx_last, .tx_sofc1, .conn_remove, .ack_dt_req,
      .seq_abort, .conn_end_seen, .conn_open_seen, .els_req_seen, .els_rep_seen);
   peer_port u_peer (.core_clk, .rst_n, .slow, .tx_valid, .tx_data, .tx_last, .tx_sofc1,
      .tx_ready);
   // -------------------------------------------------------
   // shared tasks
   // -------------------------------------------------------
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e)
      begin
         miscompares++;
         $display("MISMATCH %0t seen %h exp %h", $time, s, e);
      end
   endtask : chk
   // one cycle of a bounded wait; running out ends the run
   task automatic tick(inout int n);
      @(negedge core_clk);
      n++;
      if (n > 300)
      begin
         miscompares++;
         print_verdict();
      end
   endtask : tick
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      int n = 0;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do tick(n); while (s_axi_awready !== 1'b1);
      @(posedge core_clk);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do tick(n); while (s_axi_bvalid !== 1'b1);
      chk(s_axi_bresp, e);
      @(posedge core_clk);
      s_axi_bready <= 1'b0;
   endtask : axw
   task automatic axr(input logic [7:0] a, input logic [1:0] e, input logic [31:0] d);
      int n = 0;
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do tick(n); while (s_axi_arready !== 1'b1);
      @(posedge core_clk);
      s_axi_arvalid <= 1'b0;
      do tick(n); while (s_axi_rvalid !== 1'b1);
      chk(s_axi_rresp, e);
      chk(s_axi_rdata, d);
      @(posedge core_clk);
      s_axi_rready <= 1'b0;
   endtask : axr
   // hand one command over and wait until its frame has left
   task automatic send(input bls_pkg::op_t op, input logic [7:0] k, c, input logic [1:0] f);
      int n = 0;
      @(posedge core_clk);
      cmd_op <= op;
      cmd_d_id <= {k, 16'h0b0c};
      cmd_s_id <= {16'h1122, k};
      cmd_ox_id <= {k, 8'h34};
      cmd_rx_id <= {8'h56, k};
      cmd_seq_cnt <= {8'h00, k};
      cmd_code <= c;
      cmd_ec <= f[0];
      cmd_sofc1 <= f[1];
      cmd_valid <= 1'b1;
      do tick(n); while (cmd_ready !== 1'b1);
      @(posedge core_clk);
      cmd_valid <= 1'b0;
      do tick(n); while (tx_valid !== 1'b1);
      do tick(n); while (tx_valid !== 1'b0);
   endtask : send
   task automatic hdr(input logic [7:0] rc, input logic [3:0] len, input logic sw);
      chk(u_peer.nw, len);
      chk(u_peer.w[0], {rc, sw ? cmd_s_id : cmd_d_id});
      chk(u_peer.w[1], {8'h00, sw ? cmd_d_id : cmd_s_id});
      chk(u_peer.w[4], {cmd_ox_id, cmd_rx_id});
   endtask : hdr
   // -------------------------------------------------------
   // scenarios
   // -------------------------------------------------------
   task automatic t_acc();
      for (int i = 0; i < 2; i++)
      begin
         axw(`REG_CTRL, i ? 32'h0 : 32'h6, `RESP_OKAY);
         axw(`REG_LASTSEQ, i ? 32'h0 : 32'h1a5, `RESP_OKAY);
         slow <= i[0];
         send(bls_pkg::op_abts_reply, 8'(8'h21 + i), 8'h00, 2'b00);
         hdr(`RCTL_BA_ACC, `LAST_ACC + 4'h1, 1'b1);
         chk(u_peer.w[2][16], !i);
         chk(u_peer.w[2][20], !i);
         chk(u_peer.w[6], i ? 32'h0 : 32'h80a50000);
         chk(u_peer.w[7], {cmd_ox_id, cmd_rx_id});
         chk(u_peer.w[8], i ? {cmd_seq_cnt, cmd_seq_cnt} : 32'h0000ffff);
      end
      $display("test accept done");
   endtask : t_acc
   task automatic t_rjt();
      logic [7:0] cd [0:5] = '{`RSN_INV_CMD, `RSN_LOGIC, `RSN_BUSY, `RSN_PROTO, `RSN_UNABLE,
         `RSN_VENDOR};
      logic [7:0] ex [0:2] = '{`EXPL_NONE, `EXPL_BAD_XID, `EXPL_NO_SEQ};
      for (int i = 0; i < 6; i++)
      begin
         // a later reject condition must not displace the first
         for (int j = 0; j < 2; j++)
         begin
            @(posedge core_clk);
            rej_valid <= 1'b1;
            rej_code <= j ? `RSN_PROTO : cd[i];
            rej_expl <= j ? `EXPL_NONE : ex[i % 3];
            rej_vendor <= j ? 8'h11 : 8'h5a;
            @(posedge core_clk);
            rej_valid <= 1'b0;
         end
         send(bls_pkg::op_abts_reply, 8'(8'h30 + i), 8'h00, 2'b00);
         hdr(`RCTL_BA_RJT, `LAST_RJT + 4'h1, 1'b1);
         chk(u_peer.w[6], {8'h00, cd[i], ex[i % 3], i == 5 ? 8'h5a : 8'h00});
      end
      $display("test reject done");
   endtask : t_rjt
   task automatic t_nop();
      for (int i = 1; i < 3; i++)
      begin
         send(bls_pkg::op_nop, 8'(8'h40 + i), 8'h00, 2'(i));
         hdr(`RCTL_NOP, `LAST_HDR + 4'h1, 1'b0);
         chk(u_peer.w[2][18], i == 1);
         chk(u_peer.c1, i == 2);
      end
      $display("test nop done");
   endtask : t_nop
   task automatic t_rmc();
      axw(`REG_CTRL, 32'h0, `RESP_OKAY);
      @(posedge core_clk);
      cmd_op <= bls_pkg::op_rmc;
      cmd_valid <= 1'b1;
      repeat (4) @(negedge core_clk);
      chk(cmd_ready, 1'b0);
      @(posedge core_clk);
      cmd_valid <= 1'b0;
      axw(`REG_CTRL, 32'h8, `RESP_OKAY);
      send(bls_pkg::op_rmc, 8'h51, 8'h00, 2'b00);
      hdr(`RCTL_RMC, `LAST_HDR + 4'h1, 1'b0);
      $display("test remove done");
   endtask : t_rmc
   task automatic t_els();
      logic [7:0] ec [0:3] = '{8'h03, `ELS_ESTS, `ELS_ESTC, `ELS_ADVC};
      for (int i = 0; i < 4; i++)
      begin
         send(bls_pkg::op_els_acc, 8'(8'h61 + i), ec[i], 2'b00);
         hdr({`RCTL_ELS, `INFO_SOL}, `LAST_ELS + 4'h1, 1'b1);
         chk(u_peer.w[2][31:24], `TYPE_ELS);
         chk(u_peer.w[2][20], i == 0);
         chk(u_peer.w[6], 32'h02000000);
      end
      $display("test extended done");
   endtask : t_els
   task automatic t_rx();
      logic [24:0] rt [0:5] = '{{16'h8200, 2'b00, 7'h70}, {16'h8000, 2'b10, 7'h08},
         {16'h8000, 2'b01, 7'h04}, {16'h2201, 2'b00, 7'h02}, {16'h2301, 2'b00, 7'h01},
         {16'h2200, 2'b00, 7'h00}};
      // with the clock enable low nothing is taken and no event is raised
      @(posedge core_clk);
      ce <= 1'b0;
      rx_r_ctl <= `RCTL_RMC;
      rx_type <= `TYPE_BLS;
      rx_valid <= 1'b1;
      @(posedge core_clk);
      rx_valid <= 1'b0;
      @(negedge core_clk);
      chk({cmd_ready, ev}, 8'h00);
      @(posedge core_clk);
      ce <= 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         @(posedge core_clk);
         rx_r_ctl <= rt[i][24:17];
         rx_type <= rt[i][16:9];
         rx_f_ctl <= {5'h00, rt[i][8], 18'h0};
         rx_sofc1 <= rt[i][7];
         rx_valid <= 1'b1;
         @(posedge core_clk);
         rx_valid <= 1'b0;
         @(negedge core_clk);
         chk(ev, rt[i][6:0]);
         @(negedge core_clk);
         chk(ev, 7'h00);
      end
      $display("test receive done");
   endtask : t_rx
   initial
   begin
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      axr(`REG_CTRL, `RESP_OKAY, 32'h0);
      axr(8'h40, `RESP_DECERR, 32'h0);
      axw(8'h44, 32'h1, `RESP_DECERR);
      axw(`REG_FRAMES, 32'h5, `RESP_OKAY);
      axr(`REG_FRAMES, `RESP_OKAY, 32'h0);
      $display("test bus done");
      t_acc();
      t_rjt();
      t_nop();
      t_rmc();
      t_els();
      t_rx();
      axr(`REG_FRAMES, `RESP_OKAY, 32'h0000000f);
      print_verdict();
   end
endmodule : testbench
